// ### psh_ctrl.sv
// Host controller that drives an asynchronous pseudo-static memory over its pins.
//
// Overview of operation
// - Write lasts only while select and store strobe are both low.
// - Host times write data against the control edge ending the write.
// - Reads are select-controlled; address stable before select falls.
// - Address stable no later than 10 ns into the read cycle.
// - Avoid short invalid addresses over 15 us; deselect a read period instead.
// - Host drives data only after the device outputs have turned off.
`timescale 1ns/10ps
`default_nettype none

module psh_ctrl
  import psh_pkg::*;
#(
  parameter int ACCESS_CYCLES = ACCESS_CYC,
  parameter int PULSE_CYCLES  = PULSE_CYC,
  parameter int REST_CYCLES   = READ_PERIOD_CYC
)
(
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              rst,
  // User request.
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  // User answer.
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  // Memory control pins.
  output logic                   device_select_n,
  output logic                   output_drive_n,
  output logic                   store_strobe_n,
  output logic      [ADDR_W-1:0] word_select_pins,
  // Memory data pins.
  input  wire logic [DATA_W-1:0] data_pins_in,
  output logic      [DATA_W-1:0] data_pins_out,
  output logic                   data_pins_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks.
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 2**TMR_W)
  begin : g_chk_access
    $error("ACCESS_CYCLES out of range");
  end
  if (PULSE_CYCLES < SETUP_CYC || PULSE_CYCLES > 2**TMR_W)
  begin : g_chk_pulse
    $error("PULSE_CYCLES out of range");
  end
  if (REST_CYCLES < TURN_CYC || REST_CYCLES > 2**TMR_W)
  begin : g_chk_rest
    $error("REST_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_READ,
    ST_WRITE,
    ST_HOLD,
    ST_REST
  } psh_state_t;
  psh_state_t        state_q;
  psh_state_t        state_d;
  logic              write_q;
  logic              write_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              ce_q;
  logic              ce_d;
  logic              oe_q;
  logic              oe_d;
  logic              we_q;
  logic              we_d;
  logic              doe_q;
  logic              doe_d;
  logic              ready_q;
  logic              ready_d;
  logic              resp_q;
  logic              resp_d;
  logic              tmr_load;
  logic [TMR_W-1:0]  tmr_val;
  logic              tmr_done;
  psh_timer #(.W (TMR_W)) u_timer (
    .mclk     (mclk),
    .rst      (rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_done)
  );
  always_comb
  begin
    state_d  = state_q;
    write_d  = write_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    rdata_d  = rdata_q;
    ce_d     = ce_q;
    oe_d     = oe_q;
    we_d     = we_q;
    doe_d    = doe_q;
    ready_d  = ready_q;
    resp_d   = 1'b0;
    tmr_load = 1'b0;
    tmr_val  = '0;
    case (state_q)
      ST_IDLE:
      begin
        // Address and data settle while the device is still deselected.
        if (req_valid && ready_q)
        begin
          addr_d  = req_addr;
          wdata_d = req_wdata;
          write_d = req_write;
          doe_d   = req_write;
          ready_d = 1'b0;
          state_d = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        ce_d = 1'b0;
        if (write_q)
        begin
          we_d     = 1'b0;
          tmr_load = 1'b1;
          tmr_val  = TMR_W'(PULSE_CYCLES - 1);
          state_d  = ST_WRITE;
        end
        else
        begin
          oe_d     = 1'b0;
          tmr_load = 1'b1;
          tmr_val  = TMR_W'(ACCESS_CYCLES - 1);
          state_d  = ST_READ;
        end
      end
      ST_READ:
      begin
        if (tmr_done)
        begin
          rdata_d  = data_pins_in;
          resp_d   = 1'b1;
          ce_d     = 1'b1;
          oe_d     = 1'b1;
          tmr_load = 1'b1;
          tmr_val  = TMR_W'(REST_CYCLES - 1);
          state_d  = ST_REST;
        end
      end
      ST_WRITE:
      begin
        // Both controls rise on one edge, with data held past it.
        if (tmr_done)
        begin
          ce_d    = 1'b1;
          we_d    = 1'b1;
          state_d = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        doe_d    = 1'b0;
        resp_d   = 1'b1;
        tmr_load = 1'b1;
        tmr_val  = TMR_W'(REST_CYCLES - 1);
        state_d  = ST_REST;
      end
      ST_REST:
      begin
        // A full read period deselected after every access.
        if (tmr_done)
        begin
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      write_q <= 1'b0;
      addr_q  <= ADDR_RST;
      wdata_q <= DATA_RST;
      rdata_q <= DATA_RST;
      ce_q    <= CTRL_OFF;
      oe_q    <= CTRL_OFF;
      we_q    <= CTRL_OFF;
      doe_q   <= DRIVE_OFF;
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      write_q <= write_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      ce_q    <= ce_d;
      oe_q    <= oe_d;
      we_q    <= we_d;
      doe_q   <= doe_d;
      ready_q <= ready_d;
      resp_q  <= resp_d;
    end
  end
  assign req_ready        = ready_q;
  assign rsp_valid        = resp_q;
  assign rsp_rdata        = rdata_q;
  assign device_select_n  = ce_q;
  assign output_drive_n   = oe_q;
  assign store_strobe_n   = we_q;
  assign word_select_pins = addr_q;
  assign data_pins_out    = wdata_q;
  assign data_pins_oe     = doe_q;
  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [TMR_W:0] lo_cnt_q;
  logic [TMR_W:0] lo_cnt_d;
  logic [TMR_W:0] hi_cnt_q;
  logic [TMR_W:0] hi_cnt_d;
  // Deselect count starts saturated: the gap applies between accesses, not after reset.
  always_comb
  begin
    lo_cnt_d = ce_q ? '0 : lo_cnt_q + (TMR_W+1)'(1);
    hi_cnt_d = !ce_q ? '0 : (hi_cnt_q == '1) ? hi_cnt_q : hi_cnt_q + (TMR_W+1)'(1);
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lo_cnt_q <= '0;
      hi_cnt_q <= '1;
    end
    else
    begin
      lo_cnt_q <= lo_cnt_d;
      hi_cnt_q <= hi_cnt_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_strobe_in_select:  assert property (!we_q |-> !ce_q)
    else $error("store strobe low while deselected");
  a_write_end_edge:    assert property ($rose(we_q) |-> $rose(ce_q) && doe_q)
    else $error("write not ended by one edge with data held");
  a_write_data_held:   assert property (!we_q |-> doe_q && $stable(wdata_q))
    else $error("write data not stable while strobe low");
  a_addr_before_sel:   assert property ($fell(ce_q) |-> $stable(addr_q))
    else $error("address changed as select fell");
  a_addr_hold_select:  assert property (!ce_q |-> $stable(addr_q))
    else $error("address moved while selected");
  a_read_full_length:  assert property ($rose(ce_q) && !write_q |->
                                        $past(lo_cnt_q) == (TMR_W+1)'(ACCESS_CYCLES - 1))
    else $error("read select time wrong");
  a_deselect_gap:      assert property ($fell(ce_q) |-> $past(hi_cnt_q) >= (TMR_W+1)'(REST_CYCLES))
    else $error("deselect gap shorter than a read period");
  a_drive_after_off:   assert property ($rose(doe_q) |-> ce_q && oe_q && $past(oe_q, TURN_CYC))
    else $error("host drives data while device may drive");
  a_no_drive_on_read:  assert property (!oe_q |-> !doe_q && we_q)
    else $error("host drive overlaps device output enable");
  c_read_done:   cover property (resp_q && !write_q);
  c_write_done:  cover property (resp_q && write_q);
  c_write_read:  cover property (resp_q && write_q ##[1:40] resp_q && !write_q);
  c_back_to_back: cover property (req_valid && ready_q ##[1:40] req_valid && ready_q);
endmodule : psh_ctrl

`default_nettype wire

// ### psh_ctrl_test.sv
// Self-checking testbench for the pseudo-static memory host controller.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, (a), (b)); end end

module psh_ctrl_test;
  import psh_pkg::*;
  localparam int ACC = 2;
  localparam int PUL = 5;
  localparam int RSTC = 5;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic              req_ready, rsp_valid, device_select_n, output_drive_n;
  logic              store_strobe_n, data_pins_oe, mem_oe;
  logic [DATA_W-1:0] rsp_rdata, data_pins_out, data_wire, mem_dq;
  logic [ADDR_W-1:0] word_select_pins;
  int                err_count = 0;
  int                checks_done = 0;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] used [$];
  logic [15:0]       seed = 16'h005F;

  always #2.5 mclk = ~mclk;
  assign data_wire = data_pins_oe ? data_pins_out : (mem_oe ? mem_dq : ~data_pins_out);

  psh_ctrl #(.ACCESS_CYCLES(ACC), .PULSE_CYCLES(PUL), .REST_CYCLES(RSTC)) psh_ctrl_i (
    .mclk, .rst, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid,
    .rsp_rdata, .device_select_n, .output_drive_n, .store_strobe_n, .word_select_pins,
    .data_pins_in(data_wire), .data_pins_out, .data_pins_oe);

  psh_mem_model #(.DLY_NS(ACC * CLK_PERIOD_NS - 1)) psh_mem_model_i (
    .device_select_n, .output_drive_n, .store_strobe_n, .word_select_pins,
    .data_wire, .mem_dq, .mem_oe);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // One request from the edge after entry; returns at the edge it may be taken again.
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge mclk);
    req_valid <= 1'b0;
    do
    begin
      @(negedge mclk);
      n++;
      if (!device_select_n) `CHK(word_select_pins, a)
    end while (rsp_valid !== 1'b1 && n < 50);
    `CHK(n, w ? 3 + PUL : 2 + ACC)
    if (!w) `CHK(rsp_rdata, ref_mem[a])
    `CHK(device_select_n, 1'b1)
    do
    begin
      @(negedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 80);
    `CHK(n, (w ? 3 + PUL : 2 + ACC) + RSTC)
    if (w)
    begin
      ref_mem[a] = d;
      used.push_back(a);
    end
    @(posedge mclk);
  endtask : access

  ////////////////////////////////////////////////////////////////////////////
  // Host and memory must never drive the data pins together.
  always @(negedge mclk)
    if (!rst) `CHK(data_pins_oe & mem_oe, 1'b0)

  initial
  begin
    #100000;
    err_count++;
    close_out();
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK({device_select_n, output_drive_n, store_strobe_n, data_pins_oe, req_ready}, 5'h1D)
    @(posedge mclk);
    access(1'b1, 19'h0_0000, 8'hA5);
    access(1'b1, 19'h7_FFFF, 8'h3C);
    access(1'b0, 19'h7_FFFF, 8'h00);
    access(1'b0, 19'h0_0000, 8'h00);
    access(1'b1, 19'h0_0000, 8'h5A);
    access(1'b0, 19'h0_0000, 8'h00);
    repeat (12)
    begin
      seed = lfsr(seed);
      access(1'b1, {seed[2:0], seed}, seed[7:0]);
      seed = lfsr(seed);
      access(1'b0, used[seed % used.size()], 8'h00);
    end
    // A second reset in mid-read must leave the memory deselected.
    req_valid <= 1'b1;
    req_write <= 1'b0;
    @(posedge mclk);
    req_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b1;
    @(negedge mclk);
    `CHK({device_select_n, output_drive_n, data_pins_oe, rsp_valid}, 4'hC)
    @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK(req_ready, 1'b1)
    @(posedge mclk);
    access(1'b0, 19'h7_FFFF, 8'h00);
    close_out();
  end
endmodule : psh_ctrl_test
`default_nettype wire

// ### psh_mem_model.sv
// Behavioural pseudo-static memory that answers the controller's pins.
`timescale 1ns/10ps
`default_nettype none

module psh_mem_model
  import psh_pkg::*;
#(
  parameter int DLY_NS = 9
)
(
  // Control pins.
  input  wire logic              device_select_n,
  input  wire logic              output_drive_n,
  input  wire logic              store_strobe_n,
  input  wire logic [ADDR_W-1:0] word_select_pins,
  // Data pins.
  input  wire logic [DATA_W-1:0] data_wire,
  output logic      [DATA_W-1:0] mem_dq,
  output logic                   mem_oe
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic              wr_on  = 1'b0;
  logic              acc_ok = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Drives only when selected, enabled and not strobed; until the access
  // time has run out it shows the low address byte XOR C3 in place of the stored byte.
  assign mem_oe = !device_select_n && !output_drive_n && store_strobe_n;
  always @(word_select_pins or acc_ok)
  begin
    if (acc_ok && mem.exists(word_select_pins))
      mem_dq = mem[word_select_pins];
    else
      mem_dq = word_select_pins[DATA_W-1:0] ^ 8'hC3;
  end

  always @(negedge device_select_n)
  begin
    acc_ok = 1'b0;
    #(DLY_NS) acc_ok = !device_select_n;
  end

  always @(posedge device_select_n) acc_ok = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Stores at the release of whichever control ends the write.
  always @(device_select_n or store_strobe_n)
  begin
    if (wr_on && (device_select_n || store_strobe_n)) mem[word_select_pins] = data_wire;
    wr_on = !device_select_n && !store_strobe_n;
  end
endmodule : psh_mem_model
`default_nettype wire

// ### psh_pkg.sv
// Constants shared by the pseudo-static memory host controller.
package psh_pkg;

  // Pin and timer widths.
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int TMR_W  = 8;

  // Clock and device timing figures, in nanoseconds.
  localparam int CLK_PERIOD_NS      = 5;
  localparam int READ_PERIOD_NS     = 70;
  localparam int SELECT_TO_DATA_NS  = 70;
  localparam int WRITE_PULSE_NS     = 60;
  localparam int DATA_SETUP_NS      = 25;
  localparam int OUT_OFF_NS         = 25;
  localparam int ADDR_SKEW_LIMIT_NS = 10;

  // Cycle counts derived from the figures above, least times rounded up.
  localparam int READ_PERIOD_CYC = (READ_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC      = (SELECT_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC       = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC       = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC        = (OUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset values of the pin and user registers.
  localparam logic              CTRL_OFF  = 1'h1;
  localparam logic              DRIVE_OFF = 1'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 19'h0_0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;

endpackage : psh_pkg

// ### psh_timer.sv
// Down-counter that times the read, write and rest phases of a memory access.
`timescale 1ns/10ps
`default_nettype none

module psh_timer
  import psh_pkg::*;
#(
  parameter int W = TMR_W
)
(
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst,
  // Load and status.
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  if (W < 1)
  begin : g_chk_width
    $error("W out of range");
  end

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  always_comb
  begin
    count_d = count_q;
    if (load)
    begin
      count_d = load_val;
    end
    else if (count_q != '0)
    begin
      count_d = count_q - W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign expired = (count_q == '0);

endmodule : psh_timer

`default_nettype wire
